// *** pss_consts.svh ***
// Constants shared by both ends of the two-wire register port.
`ifndef PSS_CONSTS_SVH
`define PSS_CONSTS_SVH

// ----------------------------------------------------------------
// Addressing and framing
// ----------------------------------------------------------------
`define PSS_SLAVE_ADDR 7'h7E
`define PSS_LAST_DATA_BIT 4'h7
`define PSS_ACK_SLOT 4'h8
`define PSS_REG_ADDR_RST 8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
// Reference clock cycles per quarter of a serial clock period.
`define PSS_QUARTER_CYCLES 250

`endif

// *** pss_pkg.sv ***
// Types shared by both ends of the two-wire register port.
`default_nettype none

package pss_pkg;

   // ----------------------------------------------------------------
   // Master operations
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      mop_start,
      mop_stop,
      mop_write,
      mop_read
   } pss_op_t;

   // ----------------------------------------------------------------
   // Slave byte engine states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ss_idle,
      ss_addr,
      ss_addr_ack,
      ss_wr,
      ss_wr_ack,
      ss_rd,
      ss_rd_ack,
      ss_ignore
   } pss_sstate_t;

endpackage : pss_pkg

`default_nettype wire

// *** pss_if.sv ***
// Open-drain two-wire bus joining the master and the slave.
`timescale 1ns/1ps
`default_nettype none

interface pss_if;

   // ----------------------------------------------------------------
   // Per-end drivers and resolved wire levels
   // ----------------------------------------------------------------
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;

   // Pull-ups hold a line high unless some end enables its low drive.
   assign scl = scl_oe ? scl_o : 1'b1;
   assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

   modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                   input scl, input sda);
   modport slave (input scl, input sda, output sda_s_o, output sda_s_oe);

endinterface : pss_if

`default_nettype wire

// *** pss_master.sv ***
// Bus master end: byte-level command port driving the two-wire bus.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"

module pss_master
   import pss_pkg::*;
#(
   parameter int QUARTER_CYCLES = `PSS_QUARTER_CYCLES
) (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rst_n,
   // Serial bus.
   pss_if.master bus,
   // Command side.
   input wire logic cmd_valid,
   input wire pss_op_t cmd_op,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_nack,
   output logic cmd_ready,
   // Answer side.
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_ack,
   output logic bus_busy
);

   logic [15:0] qcnt;
   logic tick;
   logic [1:0] phase;
   logic [3:0] bit_idx;
   pss_op_t cur_op;
   logic [7:0] tx;
   logic [7:0] rx;
   logic nack;
   logic scl_oe;
   logic sda_oe;
   logic sda_meta;
   logic sda_sync;
   logic drive_low;

   // ----------------------------------------------------------------
   // Divider and line synchroniser
   // ----------------------------------------------------------------
   // The divider runs only while an operation is in progress.
   assign tick = !cmd_ready && (qcnt == 16'(QUARTER_CYCLES - 1));

   // Quarter counter restarts on every take, so each operation opens on a full quarter.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         qcnt <= 16'h0000;
      end else if (cmd_ready || tick) begin
         qcnt <= 16'h0000;
      end else begin
         qcnt <= 16'(qcnt + 16'h0001);
      end
   end

   // The data line may be driven by the slave on another clock.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
      end
   end

   // Low drive of the current bit: data, acknowledge or release.
   always_comb begin
      drive_low = 1'b0;
      if (cur_op == mop_write && bit_idx != `PSS_ACK_SLOT) begin
         drive_low = ~tx[7];
      end else if (cur_op == mop_read && bit_idx == `PSS_ACK_SLOT) begin
         drive_low = ~nack;
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   // One quarter per step; data bits only move while the clock is held low, start and stop move data while it is high.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd_ready <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
         phase <= 2'h0;
         bit_idx <= 4'h0;
         cur_op <= mop_stop;
         tx <= 8'h00;
         rx <= 8'h00;
         nack <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (cmd_ready && cmd_valid) begin
            cmd_ready <= 1'b0;
            cur_op <= cmd_op;
            tx <= cmd_data;
            nack <= cmd_nack;
            phase <= 2'h0;
            bit_idx <= 4'h0;
         end else if (tick) begin
            phase <= 2'(phase + 2'h1);
            unique case (cur_op)
               mop_start: begin
                  // Data falls while the clock is high.
                  unique case (phase)
                     2'h0: sda_oe <= 1'b0;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b1;
                     2'h3: scl_oe <= 1'b1;
                  endcase
               end
               mop_stop: begin
                  // Data rises while the clock is high.
                  unique case (phase)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     2'h3: sda_oe <= 1'b0;
                  endcase
               end
               mop_write, mop_read: begin
                  unique case (phase)
                     2'h0: sda_oe <= drive_low;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: begin
                        if (bit_idx == `PSS_ACK_SLOT) begin
                           rsp_ack <= ~sda_sync;
                        end else begin
                           rx <= {rx[6:0], sda_sync};
                        end
                     end
                     2'h3: begin
                        scl_oe <= 1'b1;
                        tx <= {tx[6:0], 1'b0};
                        bit_idx <= 4'(bit_idx + 4'h1);
                     end
                  endcase
               end
            endcase
            // Completion at the end of the last quarter.
            if (phase == 2'h3 && (bit_idx == `PSS_ACK_SLOT ||
                cur_op == mop_start || cur_op == mop_stop)) begin
               cmd_ready <= 1'b1;
               rsp_valid <= 1'b1;
               rsp_data <= rx;
            end
         end
      end
   end

   // Busy from a start until the stop completes.
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_busy <= 1'b0;
      end else if (tick && phase == 2'h2 && cur_op == mop_start) begin
         bus_busy <= 1'b1;
      end else if (tick && phase == 2'h3 && cur_op == mop_stop) begin
         bus_busy <= 1'b0;
      end
   end

   assign bus.scl_o = 1'b0;
   assign bus.sda_m_o = 1'b0;
   assign bus.scl_oe = scl_oe;
   assign bus.sda_m_oe = sda_oe;

endmodule : pss_master

`default_nettype wire

// *** pss_slave.sv ***
// Slave end: two-wire register port of the power management unit.
`timescale 1ns/1ps
`default_nettype none
`include "pss_consts.svh"

module pss_slave
   import pss_pkg::*;
#(
   parameter logic [6:0] SLAVE_ADDR = `PSS_SLAVE_ADDR
) (
   // Link clock and reset.
   input wire logic link_clk,
   input wire logic rst_n,
   // Serial bus.
   pss_if.slave bus,
   // Register side.
   output logic [7:0] reg_addr,
   output logic [7:0] wr_data,
   output logic wr_strobe,
   input wire logic [7:0] rd_data,
   output logic bus_busy
);

   logic scl_meta;
   logic scl_sync;
   logic scl_dly;
   logic sda_meta;
   logic sda_sync;
   logic sda_dly;
   logic scl_f;
   logic sda_f;
   logic scl_p;
   logic sda_p;
   logic scl_rise;
   logic scl_fall;
   logic start_ev;
   logic stop_ev;
   pss_sstate_t state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic sda_oe;
   logic rd_mode;
   logic need_ptr;
   logic wr_inc;
   logic load_pend;
   logic master_ack;

   // ----------------------------------------------------------------
   // Line conditioning
   // ----------------------------------------------------------------
   // Two flip-flops per line before anything looks at the levels.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end else begin
         scl_meta <= bus.scl;
         scl_sync <= scl_meta;
         sda_meta <= bus.sda;
         sda_sync <= sda_meta;
      end
   end

   // A level is taken only after two equal samples, which rejects
   // single-sample glitches at the cost of one cycle of latency.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_dly <= 1'b1;
         sda_dly <= 1'b1;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_p <= 1'b1;
         sda_p <= 1'b1;
      end else begin
         scl_dly <= scl_sync;
         sda_dly <= sda_sync;
         if (scl_sync == scl_dly) begin
            scl_f <= scl_sync;
         end
         if (sda_sync == sda_dly) begin
            sda_f <= sda_sync;
         end
         scl_p <= scl_f;
         sda_p <= sda_f;
      end
   end

   // Edges and bus conditions come from the filtered levels only.
   assign scl_rise = scl_f & ~scl_p;
   assign scl_fall = ~scl_f & scl_p;
   assign start_ev = scl_f & scl_p & sda_p & ~sda_f;
   assign stop_ev = scl_f & scl_p & ~sda_p & sda_f;

   // ----------------------------------------------------------------
   // Bus busy tracking
   // ----------------------------------------------------------------
   // Busy drops at once on a stop; no extra hold time is kept.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         bus_busy <= 1'b0;
      end else if (start_ev) begin
         bus_busy <= 1'b1;
      end else if (stop_ev) begin
         bus_busy <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Byte engine
   // ----------------------------------------------------------------
   // Any data change while the clock is high is a start or a stop,
   // and either one abandons whatever byte was in flight.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ss_idle;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         sda_oe <= 1'b0;
         rd_mode <= 1'b0;
         need_ptr <= 1'b0;
         wr_inc <= 1'b0;
         load_pend <= 1'b0;
         master_ack <= 1'b0;
         reg_addr <= `PSS_REG_ADDR_RST;
         wr_data <= 8'h00;
         wr_strobe <= 1'b0;
      end else begin
         wr_strobe <= 1'b0;
         if (start_ev) begin
            state <= ss_addr;
            bit_cnt <= 4'h0;
            sda_oe <= 1'b0;
            load_pend <= 1'b0;
            wr_inc <= 1'b0;
         end else if (stop_ev) begin
            state <= ss_idle;
            sda_oe <= 1'b0;
            load_pend <= 1'b0;
            wr_inc <= 1'b0;
         end else begin
            unique case (state)
               ss_idle, ss_ignore: begin
                  sda_oe <= 1'b0;
               end
               ss_addr, ss_wr: begin
                  if (scl_rise) begin
                     shreg <= {shreg[6:0], sda_f};
                     bit_cnt <= 4'(bit_cnt + 4'h1);
                  end else if (scl_fall && bit_cnt == `PSS_ACK_SLOT) begin
                     bit_cnt <= 4'h0;
                     if (state == ss_addr) begin
                        if (shreg[7:1] == SLAVE_ADDR) begin
                           state <= ss_addr_ack;
                           sda_oe <= 1'b1;
                           rd_mode <= shreg[0];
                        end else begin
                           state <= ss_ignore;
                        end
                     end else begin
                        state <= ss_wr_ack;
                        sda_oe <= 1'b1;
                        if (need_ptr) begin
                           reg_addr <= shreg;
                           need_ptr <= 1'b0;
                        end else begin
                           wr_data <= shreg;
                           wr_strobe <= 1'b1;
                           wr_inc <= 1'b1;
                        end
                     end
                  end
               end
               ss_addr_ack: begin
                  if (scl_fall) begin
                     if (rd_mode) begin
                        state <= ss_rd;
                        shreg <= rd_data;
                        sda_oe <= ~rd_data[7];
                     end else begin
                        state <= ss_wr;
                        sda_oe <= 1'b0;
                        need_ptr <= 1'b1;
                     end
                  end
               end
               ss_wr_ack: begin
                  if (scl_fall) begin
                     state <= ss_wr;
                     sda_oe <= 1'b0;
                     wr_inc <= 1'b0;
                     if (wr_inc) begin
                        reg_addr <= 8'(reg_addr + 8'h01);
                     end
                  end
               end
               ss_rd: begin
                  // The next register's data is fetched one cycle after
                  // the address moves, well inside the clock low phase.
                  if (load_pend) begin
                     load_pend <= 1'b0;
                     shreg <= rd_data;
                     sda_oe <= ~rd_data[7];
                  end else if (scl_fall) begin
                     if (bit_cnt == `PSS_LAST_DATA_BIT) begin
                        state <= ss_rd_ack;
                        sda_oe <= 1'b0;
                        bit_cnt <= 4'h0;
                     end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                        bit_cnt <= 4'(bit_cnt + 4'h1);
                     end
                  end
               end
               ss_rd_ack: begin
                  if (scl_rise) begin
                     master_ack <= ~sda_f;
                  end else if (scl_fall) begin
                     if (master_ack) begin
                        state <= ss_rd;
                        reg_addr <= 8'(reg_addr + 8'h01);
                        load_pend <= 1'b1;
                     end else begin
                        state <= ss_ignore;
                     end
                  end
               end
            endcase
         end
      end
   end

   // Open drain: the slave only ever pulls the data line low.
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = sda_oe;

endmodule : pss_slave

`default_nettype wire

// *** pss_slave_asserts.sv ***
// Concurrent checks on the two-wire bus and the slave's register side.
`timescale 1ns/1ps
`default_nettype none

module pss_slave_asserts (
   // Link clock and reset.
   input wire logic link_clk,
   input wire logic rst_n,
   // Resolved wires and slave drive.
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_s_oe,
   // Slave register side.
   input wire logic bus_busy,
   input wire logic wr_strobe,
   input wire logic [7:0] reg_addr
);

   // ----------------------------------------------------------------
   // Helper logic
   // ----------------------------------------------------------------
   logic [7:0] last_wr_addr;

   // Keeps the target of the latest stored byte, so the step can be judged later.
   always_ff @(posedge link_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_wr_addr <= 8'h00;
      end else if (wr_strobe) begin
         last_wr_addr <= reg_addr;
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // All checks sample in the link domain, where the slave lives.
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_n);

   AST_START_SETS_BUSY: assert property (scl && $fell(sda) |-> ##[1:8] bus_busy)
      else $error("busy not raised after start");
   AST_STOP_CLEARS_BUSY: assert property (scl && $rose(sda) |-> ##[1:8] !bus_busy)
      else $error("busy not cleared after stop");
   AST_IDLE_RELEASED: assert property (!bus_busy |-> !sda_s_oe)
      else $error("slave drives data while bus idle");
   AST_STABLE_CLOCK_HIGH: assert property (scl && $past(scl) |-> $stable(sda_s_oe))
      else $error("slave changed data while clock high");
   AST_DRIVE_FROM_LOW: assert property ($rose(sda_s_oe) |-> !scl ##1 sda_s_oe [*3])
      else $error("slave drive not begun in low phase or not held");
   AST_STROBE_IN_FRAME: assert property (wr_strobe |-> bus_busy && !scl)
      else $error("store strobe outside a frame");
   AST_STROBE_ACKED: assert property (wr_strobe |-> ##[0:2] sda_s_oe)
      else $error("stored byte not acknowledged");
   AST_ADDR_STEPS: assert property (wr_strobe |-> ##[1:40] reg_addr == last_wr_addr + 8'h01)
      else $error("register address did not advance");

   // Stored-byte scenario seen.
   COV_STORE: cover property (wr_strobe);

endmodule : pss_slave_asserts

`default_nettype wire

// *** test_pmu_serial_register_slave.sv ***
// Self-checking bench: master and slave ends joined over the two-wire bus.
`timescale 1ns/1ps
`default_nettype none

module test_pmu_serial_register_slave
   import pss_pkg::*;
;

   // ----------------------------------------------------------------
   // Clocks, reset and stimulus
   // ----------------------------------------------------------------
   logic ref_clk;
   logic link_clk;
   logic rst_n;
   logic cmd_valid;
   pss_op_t cmd_op;
   logic [7:0] cmd_data;
   logic cmd_nack;
   logic cmd_ready;
   logic rsp_valid;
   logic [7:0] rsp_data;
   logic rsp_ack;
   logic m_busy;
   logic s_busy;
   logic [7:0] reg_addr;
   logic [7:0] wr_data;
   logic wr_strobe;
   logic [7:0] rd_data;
   logic [8:0] wire_sh;
   logic [15:0] wq[$];
   int n_fail;
   int tests_run;
   int cycles;

   pss_if bus();

   // A quarter of 16 keeps each clock low phase at least ten link cycles long.
   pss_master #(.QUARTER_CYCLES(16)) pss_master_i (
      .ref_clk(ref_clk), .rst_n(rst_n), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
      .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack),
      .bus_busy(m_busy)
   );

   pss_slave pss_slave_i (
      .link_clk(link_clk), .rst_n(rst_n), .bus(bus), .reg_addr(reg_addr),
      .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_data(rd_data), .bus_busy(s_busy)
   );

   pss_slave_asserts pss_slave_asserts_i (
      .link_clk(link_clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
      .sda_s_oe(bus.sda_s_oe), .bus_busy(s_busy), .wr_strobe(wr_strobe),
      .reg_addr(reg_addr)
   );

   // Register contents are a fixed pattern of the address, easy to predict.
   assign rd_data = reg_addr ^ 8'h5A;

   // Clocks of unrelated phase.
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      link_clk = 1'b0;
      #7;
      forever #16 link_clk = ~link_clk;
   end

   // Wire monitor shifts in the data line on each clock rise.
   always @(posedge bus.scl) begin
      wire_sh <= {wire_sh[7:0], bus.sda};
   end

   // Store monitor logs every strobed byte with its target.
   always @(posedge link_clk) begin
      if (wr_strobe === 1'b1) begin
         wq.push_back({reg_addr, wr_data});
      end
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One master operation: held until taken, then waited for under a bound.
   task automatic xfer(input pss_op_t op, input logic [7:0] d, input logic nk);
      int n;
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_nack <= nk;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 100);
      cmd_valid <= 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 2000) begin
         n_fail++;
      end
   endtask : xfer

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : close_out

   // A hang ends the run as a failure.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         n_fail++;
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = mop_start;
      cmd_data = 8'h00;
      cmd_nack = 1'b0;
      wire_sh = 9'h000;
      n_fail = 0;
      tests_run = 0;
      cycles = 0;
      // Held over link edges too, since that domain needs two of them.
      repeat (4) @(posedge link_clk);
      @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge link_clk);

      // Write two bytes from register 10h onward.
      xfer(mop_start, 8'h00, 1'b0);
      xfer(mop_write, 8'hFC, 1'b0);
      check(rsp_ack, 1'b1);
      check(wire_sh, {8'hFC, 1'b0});
      xfer(mop_write, 8'h10, 1'b0);
      check(rsp_ack, 1'b1);
      xfer(mop_write, 8'hA5, 1'b0);
      check(rsp_ack, 1'b1);
      xfer(mop_write, 8'h3C, 1'b0);
      check(rsp_ack, 1'b1);
      check(s_busy, 1'b1);
      check(m_busy, 1'b1);
      xfer(mop_stop, 8'h00, 1'b0);
      repeat (10) @(posedge link_clk);
      check(s_busy, 1'b0);
      check(m_busy, 1'b0);
      check({bus.scl, bus.sda}, 2'b11);
      check(wq.size(), 2);
      check(wq[0], {8'h10, 8'hA5});
      check(wq[1], {8'h11, 8'h3C});
      $display("test write done");

      // Pointer write, repeated start, two reads ending in a refusal.
      xfer(mop_start, 8'h00, 1'b0);
      xfer(mop_write, 8'hFC, 1'b0);
      xfer(mop_write, 8'h20, 1'b0);
      xfer(mop_start, 8'h00, 1'b0);
      xfer(mop_write, 8'hFD, 1'b0);
      check(rsp_ack, 1'b1);
      check(wire_sh, {8'hFD, 1'b0});
      xfer(mop_read, 8'h00, 1'b0);
      check(rsp_data, 8'h20 ^ 8'h5A);
      xfer(mop_read, 8'h00, 1'b1);
      check(rsp_data, 8'h21 ^ 8'h5A);
      check(bus.sda, 1'b1);
      check(bus.sda_m_oe, 1'b0);
      xfer(mop_stop, 8'h00, 1'b0);
      check(wq.size(), 2);
      $display("test read done");

      // A read with no pointer write starts at the current pointer.
      xfer(mop_start, 8'h00, 1'b0);
      xfer(mop_write, 8'hFD, 1'b0);
      xfer(mop_read, 8'h00, 1'b1);
      check(rsp_data, 8'h21 ^ 8'h5A);
      xfer(mop_stop, 8'h00, 1'b0);
      $display("test current read done");

      // Another device's address is never answered, nor its data stored.
      xfer(mop_start, 8'h00, 1'b0);
      xfer(mop_write, 8'h80, 1'b0);
      check(rsp_ack, 1'b0);
      xfer(mop_write, 8'h55, 1'b0);
      check(rsp_ack, 1'b0);
      xfer(mop_stop, 8'h00, 1'b0);
      repeat (10) @(posedge link_clk);
      check(wq.size(), 2);
      $display("test foreign address done");
      close_out();
   end

endmodule : test_pmu_serial_register_slave

`default_nettype wire
